//--- hiodw_pkg.sv
package hiodw_pkg;

  // ==========================================================
  // Host I/O address decode
  localparam int unsigned HIODW_ADDR_W   = 10;
  localparam int unsigned HIODW_BLK_LSB  = 4;
  localparam int unsigned HIODW_BLK_W    = HIODW_ADDR_W - HIODW_BLK_LSB;
  // Card base 300h: register window 300h..30fh, data port at 310h
  localparam logic [9:0]  HIODW_IO_BASE  = 10'h300;
  localparam logic [9:0]  HIODW_PORT_ADR = 10'h310;
  localparam logic [HIODW_BLK_W-1:0] HIODW_REG_BLK =
    HIODW_IO_BASE[HIODW_ADDR_W-1:HIODW_BLK_LSB];
  localparam logic [HIODW_BLK_W-1:0] HIODW_PORT_BLK =
    HIODW_PORT_ADR[HIODW_ADDR_W-1:HIODW_BLK_LSB];

  // ==========================================================
  // Pin levels arriving from the host bus and the controller
  typedef struct packed {
    logic [HIODW_ADDR_W-1:0] addr;
    logic                    aen;
    logic                    io_rd_n;
    logic                    io_wr_n;
    logic                    dma_ack_n;
    logic                    port_request;
    logic                    ctrl_ack_n;
    logic                    mem_read_strobe_n;
    logic                    mem_addr_bit_thirteen;
  } hiodw_pins_t;

  // Idle bus: strobes high, address enable high (no I/O cycle)
  localparam hiodw_pins_t HIODW_PINS_IDLE = '{
    addr:                  10'h000,
    aen:                   1'b1,
    io_rd_n:               1'b1,
    io_wr_n:               1'b1,
    dma_ack_n:             1'b1,
    port_request:          1'b0,
    ctrl_ack_n:            1'b1,
    mem_read_strobe_n:     1'b1,
    mem_addr_bit_thirteen: 1'b1
  };

  localparam int unsigned HIODW_PINS_W = $bits(hiodw_pins_t);

endpackage

//--- hiodw_sync.sv
`timescale 1ns/1ns
module hiodw_sync #(
  parameter int unsigned          WIDTH     = 1,
  parameter logic [WIDTH-1:0]     RESET_VAL = '0
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // Elaboration-time guard on the bundle width
  if (WIDTH < 1) begin : g_width_chk
    $error("hiodw_sync: WIDTH must be at least 1");
  end

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule // hiodw_sync

//--- hiodw_decode.sv
`timescale 1ns/1ns
// Behaviour
// - The register window sits at fixed base 300h and covers 300h to 30fh.
// - String transfers to the data port use address 310h both ways.
// - Register select asserts only in the window with a read or write strobe.
// - Register accesses wait while the controller is busy, until it acks.
// - Data port reads wait while the port request is still low.
// - Data port writes wait while the port request is still low.
// - Each port transfer ends with a read or write ack from DMA or port.
// - The wait line is driven only for register or data port accesses.
// - The address PROM is selected on memory read with address bit 13 low.
module hiodw_decode
(
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire hiodw_pkg::hiodw_pins_t host_pins,
  input  wire logic               host_reset_in,
  output logic                    controller_reg_select_n,
  output logic                    port_read_ack_n,
  output logic                    port_write_ack_n,
  output logic                    prom_select_n,
  output logic                    wait_out,
  output logic                    wait_drive_enable,
  output logic                    controller_reset_out
);
  import hiodw_pkg::*;

  // ==========================================================
  // Input synchronisers
  // The whole pin bundle shares one synchroniser so every decode
  // sees the same sample of address and strobes
  hiodw_pins_t pins_s;
  logic [HIODW_PINS_W-1:0] pins_raw;

  assign pins_raw = host_pins;

  hiodw_sync #(
    .WIDTH     (HIODW_PINS_W),
    .RESET_VAL (HIODW_PINS_IDLE)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (pins_raw),
    .sync_out (pins_s)
  );

  // ==========================================================
  // Decode
  logic io_rd;
  logic io_wr;
  logic dma_ack;
  logic reg_hit;
  logic port_hit;
  logic reg_sel;
  logic [HIODW_BLK_W-1:0] addr_blk;

  assign addr_blk = pins_s.addr[HIODW_ADDR_W-1:HIODW_BLK_LSB];

  logic reg_sel_q,  reg_sel_d;
  logic rd_ack_q,   rd_ack_d;
  logic wr_ack_q,   wr_ack_d;
  logic prom_q,     prom_d;
  logic wait_q,     wait_d;
  logic wait_en_q,  wait_en_d;

  always_comb begin
    io_rd    = !pins_s.io_rd_n;
    io_wr    = !pins_s.io_wr_n;
    dma_ack  = !pins_s.dma_ack_n;
    reg_hit  = !pins_s.aen &&
               pins_s.addr[HIODW_ADDR_W-1:HIODW_BLK_LSB]
                 == HIODW_REG_BLK;
    port_hit = !pins_s.aen &&
               pins_s.addr[HIODW_ADDR_W-1:HIODW_BLK_LSB]
                 == HIODW_PORT_BLK;
    reg_sel  = reg_hit && (io_rd || io_wr);

    reg_sel_d = reg_sel;
    rd_ack_d  = (port_hit && pins_s.port_request && io_rd)
              || (dma_ack && io_rd);
    wr_ack_d  = (port_hit && pins_s.port_request && io_wr)
              || (dma_ack && io_wr);
    wait_en_d = reg_sel || (port_hit && (io_rd || io_wr));
    if (reg_sel) begin
      wait_d = pins_s.ctrl_ack_n;
    end else begin
      wait_d = wait_en_d && !pins_s.port_request;
    end
    prom_d = !pins_s.mem_read_strobe_n
             && !pins_s.mem_addr_bit_thirteen;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_sel_q <= 1'b0;
      rd_ack_q  <= 1'b0;
      wr_ack_q  <= 1'b0;
      prom_q    <= 1'b0;
      wait_q    <= 1'b0;
      wait_en_q <= 1'b0;
    end else begin
      reg_sel_q <= reg_sel_d;
      rd_ack_q  <= rd_ack_d;
      wr_ack_q  <= wr_ack_d;
      prom_q    <= prom_d;
      wait_q    <= wait_d;
      wait_en_q <= wait_en_d;
    end
  end

  assign controller_reg_select_n = !reg_sel_q;
  assign port_read_ack_n         = !rd_ack_q;
  assign port_write_ack_n        = !wr_ack_q;
  assign prom_select_n           = !prom_q;
  assign wait_out                = wait_q;
  assign wait_drive_enable       = wait_en_q;
  // Pass-through so the controller resets with the host, unclocked
  assign controller_reset_out    = host_reset_in;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  reg_window_a : assert property (
    !controller_reg_select_n |->
      $past(addr_blk) == HIODW_REG_BLK)
    else $error("register select outside window");

  reg_hit_a : assert property (
    ($past(!pins_s.aen && addr_blk == HIODW_REG_BLK
       && (!pins_s.io_rd_n || !pins_s.io_wr_n)))
    |-> !controller_reg_select_n)
    else $error("window access not selected");

  port_addr_a : assert property (
    ($past(!pins_s.aen && addr_blk == HIODW_PORT_BLK
       && pins_s.port_request && !pins_s.io_rd_n))
    |-> !port_read_ack_n)
    else $error("string port read not acknowledged");

  reg_strobe_a : assert property (
    !controller_reg_select_n |->
      $past(!pins_s.io_rd_n || !pins_s.io_wr_n))
    else $error("register select without strobe");

  reg_wait_a : assert property (
    ($past(reg_sel && !pins_s.ctrl_ack_n)) |-> !wait_out)
    else $error("wait held after controller ack");

  reg_busy_a : assert property (
    ($past(reg_sel && pins_s.ctrl_ack_n)) |-> wait_out)
    else $error("no wait while controller busy");

  rd_wait_a : assert property (
    ($past(!pins_s.aen && addr_blk == HIODW_PORT_BLK
       && !pins_s.io_rd_n && !pins_s.port_request))
    |-> wait_out && wait_drive_enable)
    else $error("no wait on early port read");

  rd_release_a : assert property (
    ($past(!pins_s.aen && addr_blk == HIODW_PORT_BLK
       && !pins_s.io_rd_n && pins_s.port_request))
    |-> !wait_out && wait_drive_enable)
    else $error("port read wait not released");

  wr_wait_a : assert property (
    ($past(!pins_s.aen && addr_blk == HIODW_PORT_BLK
       && !pins_s.io_wr_n && pins_s.port_request))
    |-> !wait_out && !port_write_ack_n)
    else $error("port write not released");

  wr_early_wait_a : assert property (
    ($past(!pins_s.aen && addr_blk == HIODW_PORT_BLK
       && !pins_s.io_wr_n && !pins_s.port_request))
    |-> wait_out && wait_drive_enable && port_write_ack_n)
    else $error("no wait on early port write");

  dma_ack_a : assert property (
    $past(!pins_s.dma_ack_n && !pins_s.io_wr_n) |-> !port_write_ack_n)
    else $error("dma write not acknowledged");

  dma_rd_ack_a : assert property (
    $past(!pins_s.dma_ack_n && !pins_s.io_rd_n) |-> !port_read_ack_n)
    else $error("dma read not acknowledged");

  wait_drive_a : assert property (
    wait_out |-> wait_drive_enable)
    else $error("wait asserted while not driven");

  wait_idle_a : assert property (
    $past(pins_s.io_rd_n && pins_s.io_wr_n) |-> !wait_drive_enable)
    else $error("wait driven with no strobe");

  prom_sel_a : assert property (
    !prom_select_n == $past(!pins_s.mem_read_strobe_n
                             && !pins_s.mem_addr_bit_thirteen))
    else $error("prom select mismatch");

  aen_block_a : assert property (
    $past(pins_s.aen && pins_s.dma_ack_n)
    |-> controller_reg_select_n && port_read_ack_n && port_write_ack_n
        && !wait_drive_enable)
    else $error("decode active during dma cycle");

  reset_pass_a : assert property (
    controller_reset_out == host_reset_in)
    else $error("controller reset does not follow host");

  reg_access_c   : cover property (!controller_reg_select_n ##1
                                   controller_reg_select_n);
  reg_wait_c     : cover property (wait_out && !controller_reg_select_n
                                   ##1 !wait_out);
  port_rd_wait_c : cover property (wait_out ##1 !port_read_ack_n);
  dma_wr_c       : cover property (!port_write_ack_n && !wait_drive_enable);
  port_wr_c      : cover property (wait_out ##1 !port_write_ack_n);

endmodule // hiodw_decode

//--- hiodw_ctrl_model.sv
`timescale 1ns/1ns
module hiodw_ctrl_model (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       controller_reg_select_n,
  input  wire logic [3:0] ack_dly,
  output logic            ctrl_ack_n
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  // ==========================================================
  // Busy controller: acknowledges a selected access ack_dly cycles late
  always_comb begin
    cnt_d = cnt_q;
    if (controller_reg_select_n) begin
      cnt_d = 4'h0;
    end else if (cnt_q < ack_dly) begin
      cnt_d = cnt_q + 4'h1;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign ctrl_ack_n = controller_reg_select_n | (cnt_q < ack_dly);
endmodule // hiodw_ctrl_model

//--- hiodw_tb.sv
`timescale 1ns/1ns
module testbench;
  import hiodw_pkg::*;
  // ==========================================================
  // Clock, pins and design
  logic        ref_clk, rst, host_reset_in, ack_n, rst_out;
  logic [3:0]  dly;
  logic [5:0]  o;
  hiodw_pins_t p, pins;
  int          n_fail, num_checks;
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always_comb begin
    pins = p;
    pins.ctrl_ack_n = ack_n;
  end
  hiodw_decode dut_u (.ref_clk(ref_clk), .rst(rst), .host_pins(pins),
    .host_reset_in(host_reset_in), .controller_reg_select_n(o[5]),
    .port_read_ack_n(o[4]), .port_write_ack_n(o[3]),
    .prom_select_n(o[2]), .wait_out(o[1]), .wait_drive_enable(o[0]),
    .controller_reset_out(rst_out));
  hiodw_ctrl_model ctl_u (.ref_clk(ref_clk), .rst(rst),
    .controller_reg_select_n(o[5]), .ack_dly(dly), .ctrl_ack_n(ack_n));
  // ==========================================================
  // Helpers; wait level is ignored while its driver is off
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [5:0] e);
    num_checks++;
    if ((o & {4'hf, e[0], 1'b1}) !== e) begin
      n_fail++;
      $display("[ERR] %0t outputs %b expected %b", $time, o, e);
    end
  endtask
  task automatic chkr(input logic e);
    num_checks++;
    if (rst_out !== e) begin
      n_fail++;
      $display("[ERR] %0t reset out %b expected %b", $time, rst_out, e);
    end
  endtask
  task automatic chkc(input int got, input int e);
    num_checks++;
    if (got != e) begin
      n_fail++;
      $display("[ERR] %0t wait cycles %0d expected %0d", $time, got, e);
    end
  endtask
  task automatic results;
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic idle;
    p = HIODW_PINS_IDLE;
    step(6);
    chk(6'h3c);
  endtask
  // ==========================================================
  // Scenarios
  task automatic reg_decode;
    logic [9:0] a [4] = '{10'h300, 10'h30f, 10'h2ff, 10'h320};
    for (int i = 0; i < 10; i++) begin
      p.addr = a[i%4];
      p.aen = (i >= 8);
      p.io_rd_n = (i >= 4 && i < 8);
      p.io_wr_n = (i < 4);
      step(8);
      chk((i % 4 < 2 && i < 8) ? 6'h1d : 6'h3c);
      idle;
    end
    p.addr = 10'h305;
    p.aen = 1'b0;
    step(6);
    chk(6'h3c);
  endtask
  task automatic slow_ack;
    int k;
    dly = 4'ha;
    p.addr = 10'h305;
    p.io_rd_n = 1'b0;
    step(6);
    chk(6'h1f);
    for (k = 0; k < 30 && o[1] !== 1'b0; k++) step(1);
    if (k == 30) begin
      n_fail++;
      $display("[ERR] %0t wait never released", $time);
      results;
    end
    chk(6'h1d);
    // Select shows 3 edges after the pins, ack 10 later, wait falls 3 on
    chkc(k, 10);
    dly = 4'h0;
    idle;
  endtask
  task automatic port_xfer;
    for (int i = 0; i < 2; i++) begin
      p.addr = 10'h310;
      p.aen = 1'b0;
      p.io_rd_n = (i == 1);
      p.io_wr_n = (i == 0);
      step(6);
      chk(6'h3f);
      p.port_request = 1'b1;
      step(6);
      chk(i ? 6'h35 : 6'h2d);
      idle;
    end
  endtask
  task automatic dma_xfer;
    p.addr = 10'h310;
    p.port_request = 1'b1;
    p.io_rd_n = 1'b0;
    step(6);
    chk(6'h3c);
    idle;
    for (int i = 0; i < 2; i++) begin
      p.addr = 10'h310;
      p.dma_ack_n = 1'b0;
      p.io_rd_n = (i == 1);
      p.io_wr_n = (i == 0);
      step(6);
      chk(i ? 6'h34 : 6'h2c);
      idle;
    end
  endtask
  task automatic prom;
    p.mem_read_strobe_n = 1'b0;
    p.mem_addr_bit_thirteen = 1'b0;
    step(6);
    chk(6'h38);
    p.mem_addr_bit_thirteen = 1'b1;
    step(6);
    chk(6'h3c);
    p.mem_read_strobe_n = 1'b1;
    p.mem_addr_bit_thirteen = 1'b0;
    step(6);
    chk(6'h3c);
    idle;
  endtask
  task automatic host_reset;
    host_reset_in = 1'b1;
    #1 chkr(1'b1);
    host_reset_in = 1'b0;
    #1 chkr(1'b0);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    host_reset_in = 1'b0;
    dly = 4'h0;
    p = HIODW_PINS_IDLE;
    n_fail = 0;
    num_checks = 0;
    step(10);
    rst = 1'b0;
    idle;
    reg_decode;
    slow_ack;
    port_xfer;
    dma_xfer;
    prom;
    host_reset;
    results;
  end
endmodule // testbench
